// file: hw/drv_cmd.sv
// sector read / read-verify command interpreter behind the task file registers
`timescale 1ns/1ps
module drv_cmd #(
  parameter int WORDS_PER_SECTOR = 256,
  parameter logic [7:0] SECT_PER_TRK = 8'h3f,
  parameter logic [3:0] HEAD_MAX = 4'hf
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire drv_pkg::drv_bus_type bus,
  output logic [15:0] rdata,
  output drv_pkg::drv_med_out_type med_out,
  input wire drv_pkg::drv_med_in_type med_in,
  output logic irq
);
  import drv_pkg::*;

  localparam logic [15:0] WPS = 16'(WORDS_PER_SECTOR);

  // ==========================================================
  // reset release
  logic [1:0] rsync;
  logic rst_n;
  // two-stage release of the async reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsync <= 2'b00;
    end else begin
      rsync <= {rsync[0], 1'b1};
    end
  end
  assign rst_n = rsync[1];

  // ==========================================================
  // helpers
  // byte shown for a history register
  function automatic logic [7:0] pick(drv_hist_type h, logic upper_byte_view);
    return upper_byte_view ? h.prev : h.cur;
  endfunction

  // write shifts older byte up
  function automatic drv_hist_type push(drv_hist_type h, logic [7:0] d);
    drv_hist_type n;
    n.prev = h.cur;
    n.cur = d;
    return n;
  endfunction

  // address of the following sector
  function automatic logic [47:0] step(logic [47:0] a, logic chs);
    drv_addr_type v;
    v = drv_addr_type'(a);
    if (!chs) begin
      return a + 48'h1;
    end
    if (v.sec >= SECT_PER_TRK) begin
      v.sec = 8'h01;
      if (v.head >= HEAD_MAX) begin
        v.head = 4'h0;
        v.cyl = v.cyl + 16'h1;
      end else begin
        v.head = v.head + 4'h1;
      end
    end else begin
      v.sec = v.sec + 8'h01;
    end
    return 48'(v);
  endfunction

  // ==========================================================
  // state
  drv_regs_type r;
  drv_regs_type nx;
  logic [7:0] op;
  logic [7:0] stat;
  logic wr_opc;
  logic [IRQ_W-1:0] ev;

  assign op = bus.wdata[7:0] & OPC_MASK;
  assign wr_opc = bus.wr && bus.addr == OFS_OPC && r.st == S_IDLE;

  // status byte, fixed zeros for fault, corrected, index
  always_comb begin
    stat = 8'h00;
    stat[ST_BSY] = r.bsy;
    stat[ST_RDY] = 1'b1;
    stat[ST_DSC] = 1'b1;
    stat[ST_DRQ] = r.drq;
    stat[ST_ERR] = |r.err;
  end

  // next state
  always_comb begin
    nx = r;
    ev = '0;
    // host register writes other than the interrupt mask, ignored while busy
    if (bus.wr && !r.bsy) begin
      case (bus.addr)
        OFS_CNT: nx.cnt = push(r.cnt, bus.wdata[7:0]);
        OFS_LOW: nx.low = push(r.low, bus.wdata[7:0]);
        OFS_MID: nx.mid = push(r.mid, bus.wdata[7:0]);
        OFS_HIGH: nx.high = push(r.high, bus.wdata[7:0]);
        OFS_DRV: nx.drv = bus.wdata[7:0];
        OFS_CTL: nx.upper_byte_view = bus.wdata[CTL_HOB];
        default: ;
      endcase
    end
    if (bus.wr && bus.addr == OFS_IMSK) begin
      nx.imsk = bus.wdata[IRQ_W-1:0];
    end
    // register reads, data one cycle later
    if (bus.rd) begin
      case (bus.addr)
        OFS_WORD: nx.rdata = r.drq ? r.word : 16'h0000;
        OFS_ERR: nx.rdata = {8'h00, r.err};
        OFS_CNT: nx.rdata = {8'h00, pick(r.cnt, r.upper_byte_view)};
        OFS_LOW: nx.rdata = {8'h00, pick(r.low, r.upper_byte_view)};
        OFS_MID: nx.rdata = {8'h00, pick(r.mid, r.upper_byte_view)};
        OFS_HIGH: nx.rdata = {8'h00, pick(r.high, r.upper_byte_view)};
        OFS_DRV: nx.rdata = {8'h00, r.drv};
        OFS_OPC: nx.rdata = {8'h00, stat};
        OFS_CTL: nx.rdata = {8'h00, r.upper_byte_view, 7'h00};
        OFS_IST: nx.rdata = {13'h0000, r.ist};
        OFS_IMSK: nx.rdata = {13'h0000, r.imsk};
        default: nx.rdata = 16'h0000;
      endcase
    end
    // host pops a held word
    if (bus.rd && bus.addr == OFS_WORD && r.drq && r.full) begin
      nx.full = 1'b0;
    end
    case (r.st)
      S_IDLE: begin
        if (wr_opc) begin
          nx.err = 8'h00;
          nx.bsy = 1'b1;
          nx.lbam = r.drv[DRV_LBA];
          nx.lba = {20'h00000, r.drv[3:0], r.high.cur, r.mid.cur, r.low.cur};
          nx.left = (r.cnt.cur == 8'h00) ? CNT_256 : {9'h000, r.cnt.cur};
          nx.is48 = 1'b0;
          nx.vfy = 1'b0;
          nx.st = S_REQ;
          case (op)
            OPC_RD28: ;
            OPC_VF28: nx.vfy = 1'b1;
            OPC_RD48: begin
              nx.is48 = 1'b1;
              nx.lba = {r.high.prev, r.mid.prev, r.low.prev,
                        r.high.cur, r.mid.cur, r.low.cur};
              nx.left = ({r.cnt.prev, r.cnt.cur} == 16'h0000) ? CNT_64K
                        : {1'b0, r.cnt.prev, r.cnt.cur};
              if (!r.drv[DRV_LBA]) begin
                nx.err[ER_ABT] = 1'b1;
                nx.st = S_DONE;
              end
            end
            default: begin // unsupported opcode is aborted
              nx.err[ER_ABT] = 1'b1;
              nx.st = S_DONE;
            end
          endcase
        end
      end
      S_REQ: begin
        if (med_in.ack) begin
          if (med_in.unc || med_in.idnf) begin
            nx.err[ER_UNC] = med_in.unc;
            nx.err[ER_IDN] = med_in.idnf;
            nx.st = S_DONE;
          end else if (r.vfy) begin
            nx.st = S_NEXT;
          end else begin
            nx.drq = 1'b1;
            nx.wcnt = 16'h0000;
            ev[IQ_DRQ] = 1'b1;
            nx.st = S_XFER;
          end
        end
      end
      S_XFER: begin
        // take a media word when the holder is free
        if (med_in.word_valid && !r.full) begin
          nx.word = med_in.word;
          nx.full = 1'b1;
          nx.wcnt = r.wcnt + 16'h0001;
        end
        if (r.wcnt == WPS && !nx.full) begin
          nx.drq = 1'b0;
          nx.st = S_NEXT;
        end
      end
      S_NEXT: begin
        nx.left = r.left - CNT_ONE;
        if (r.left == CNT_ONE) begin
          nx.st = S_DONE;
        end else begin
          nx.lba = step(r.lba, !r.lbam);
          nx.st = S_REQ;
        end
      end
      S_DONE: begin
        // leave last address, and for 28-bit commands the remaining count, for the host
        if (!r.is48) begin
          nx.cnt.cur = r.left[7:0];
          nx.drv[3:0] = r.lba[27:24];
        end else begin
          nx.low.prev = r.lba[31:24];
          nx.mid.prev = r.lba[39:32];
          nx.high.prev = r.lba[47:40];
        end
        nx.low.cur = r.lba[7:0];
        nx.mid.cur = r.lba[15:8];
        nx.high.cur = r.lba[23:16];
        nx.bsy = 1'b0;
        nx.drq = 1'b0;
        ev[IQ_DONE] = 1'b1;
        ev[IQ_ERR] = |r.err;
        nx.st = S_IDLE;
      end
      default: nx.st = S_IDLE;
    endcase
    // sticky events, set wins over read clear
    nx.ist = ((bus.rd && bus.addr == OFS_IST) ? '0 : r.ist) | ev;
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= S_IDLE;
    end else if (ce) begin
      r <= nx;
    end
  end

  // outputs
  assign rdata = r.rdata;
  assign med_out.req = (r.st == S_REQ);
  assign med_out.chs = !r.lbam;
  assign med_out.lba = r.lba;
  assign med_out.word_ready = (r.st == S_XFER) && !r.full && r.wcnt != WPS;
  assign irq = |(r.ist & r.imsk);

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_bad_ack;
    ce && r.st == S_REQ && med_in.ack && med_in.unc;
  endsequence
  sequence s_stop;
    ce && r.st == S_DONE ##1 !r.bsy && r.err[ER_UNC] && !r.drq;
  endsequence

  property p_busy;
    ce && wr_opc |=> r.bsy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not raised");

  property p_stop;
    s_bad_ack |=> s_stop;
  endproperty
  a_stop: assert property (p_stop) else $error("bad sector not stopped");

  property p_vfy_nodata;
    r.vfy && r.bsy |-> !r.drq;
  endproperty
  a_vfy_nodata: assert property (p_vfy_nodata) else $error("verify requested data");

  property p_retry;
    ce && wr_opc && bus.wdata[7:0] == (OPC_VF28 | 8'h01) |=> r.vfy && !r.is48;
  endproperty
  a_retry: assert property (p_retry) else $error("retry opcode misdecoded");

  property p_cnt48;
    ce && wr_opc && op == OPC_RD48 && r.drv[DRV_LBA] && r.cnt == 16'h0000
      |=> r.left == CNT_64K && r.is48;
  endproperty
  a_cnt48: assert property (p_cnt48) else $error("48-bit zero count wrong");

  property p_cnt28;
    ce && wr_opc && op == OPC_VF28 && r.cnt.cur == 8'h00 |=> r.left == CNT_256;
  endproperty
  a_cnt28: assert property (p_cnt28) else $error("8-bit zero count wrong");

  property p_hist;
    ce && bus.wr && bus.addr == OFS_LOW && !r.bsy |=> r.low.prev == $past(r.low.cur);
  endproperty
  a_hist: assert property (p_hist) else $error("history not shifted");

  property p_abort48;
    ce && wr_opc && op == OPC_RD48 && !r.drv[DRV_LBA] |=> r.err[ER_ABT] && r.st == S_DONE;
  endproperty
  a_abort48: assert property (p_abort48) else $error("48-bit read without block mode not aborted");

  property p_lba48;
    ce && wr_opc && op == OPC_RD48 && r.drv[DRV_LBA]
      |=> r.lba[47:40] == $past(r.high.prev) && r.lba[7:0] == $past(r.low.cur);
  endproperty
  a_lba48: assert property (p_lba48) else $error("48-bit address misassembled");

  property p_left28;
    ce && r.st == S_DONE && !r.is48 |=> r.cnt.cur == $past(r.left[7:0]) && r.low.cur == $past(r.lba[7:0]);
  endproperty
  a_left28: assert property (p_left28) else $error("remaining count or address wrong");

  property p_status;
    bus.rd && bus.addr == OFS_OPC && ce
      |=> r.rdata[ST_RDY] && !r.rdata[ST_DF] && r.rdata[ST_DSC];
  endproperty
  a_status: assert property (p_status) else $error("status fixed bits wrong");

  property p_word;
    ce && bus.rd && bus.addr == OFS_WORD && r.drq |=> rdata == $past(r.word);
  endproperty
  a_word: assert property (p_word) else $error("data word not returned");

  // data request must stand until every word of the sector has moved
  property p_words;
    ce && r.st == S_XFER && r.wcnt != WPS |=> r.drq;
  endproperty
  a_words: assert property (p_words) else $error("data request dropped early");

  // sector request stands until the media answers
  property p_req_hold;
    ce && r.st == S_REQ && !med_in.ack |=> med_out.req;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("sector request dropped early");

  sequence s_good_ack;
    ce && r.st == S_REQ && med_in.ack && !med_in.unc && !med_in.idnf && !r.vfy;
  endsequence
  property p_drq;
    s_good_ack |=> r.drq && r.st == S_XFER && r.wcnt == 16'h0000;
  endproperty
  a_drq: assert property (p_drq) else $error("data request missing");

  property p_left_step;
    ce && r.st == S_NEXT |=> r.left == $past(r.left) - CNT_ONE;
  endproperty
  a_left_step: assert property (p_left_step) else $error("remaining count not stepped");

  property p_busy_refuse;
    ce && bus.wr && bus.addr == OFS_CNT && r.bsy && r.st != S_DONE |=> r.cnt == $past(r.cnt);
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("count written while busy");

  sequence s_nf_ack;
    ce && r.st == S_REQ && med_in.ack && med_in.idnf;
  endsequence
  property p_nf_stop;
    s_nf_ack |=> r.st == S_DONE && r.err[ER_IDN] && !r.drq;
  endproperty
  a_nf_stop: assert property (p_nf_stop) else $error("missing sector not stopped");
endmodule // drv_cmd

// file: hw/drv_pkg.sv
// package: register map, bit layout, opcodes and carrier types of the sector read/verify block
package drv_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] OFS_WORD = 4'h0;
  localparam logic [3:0] OFS_ERR = 4'h1;
  localparam logic [3:0] OFS_CNT = 4'h2;
  localparam logic [3:0] OFS_LOW = 4'h3;
  localparam logic [3:0] OFS_MID = 4'h4;
  localparam logic [3:0] OFS_HIGH = 4'h5;
  localparam logic [3:0] OFS_DRV = 4'h6;
  localparam logic [3:0] OFS_OPC = 4'h7;
  localparam logic [3:0] OFS_CTL = 4'h8;
  localparam logic [3:0] OFS_IST = 4'h9;
  localparam logic [3:0] OFS_IMSK = 4'ha;
  // opcodes with the retry bit masked off
  localparam logic [7:0] OPC_MASK = 8'hfe;
  localparam logic [7:0] OPC_RD28 = 8'h20;
  localparam logic [7:0] OPC_RD48 = 8'h24;
  localparam logic [7:0] OPC_VF28 = 8'h40;
  // status, error, drive and control bit positions
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DF = 5;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_UNC = 6;
  localparam int ER_IDN = 4;
  localparam int ER_ABT = 2;
  localparam int DRV_LBA = 6;
  localparam int CTL_HOB = 7;
  // interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IQ_DONE = 0;
  localparam int IQ_ERR = 1;
  localparam int IQ_DRQ = 2;
  // sector counts
  localparam logic [16:0] CNT_ONE = 17'h00001;
  localparam logic [16:0] CNT_256 = 17'h00100;
  localparam logic [16:0] CNT_64K = 17'h10000;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_REQ = 5'b00010,
    S_XFER = 5'b00100,
    S_NEXT = 5'b01000,
    S_DONE = 5'b10000
  } drv_state_type;
  // two-deep history of a parameter register
  typedef struct packed {
    logic [7:0] prev;
    logic [7:0] cur;
  } drv_hist_type;
  // 28-bit address view, geometric fields
  typedef struct packed {
    logic [19:0] pad;
    logic [3:0] head;
    logic [15:0] cyl;
    logic [7:0] sec;
  } drv_addr_type;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } drv_bus_type;
  typedef struct packed {
    logic req;
    logic chs;
    logic [47:0] lba;
    logic word_ready;
  } drv_med_out_type;
  typedef struct packed {
    logic ack;
    logic unc;
    logic idnf;
    logic word_valid;
    logic [15:0] word;
  } drv_med_in_type;
  typedef struct packed {
    drv_state_type st;
    drv_hist_type cnt;
    drv_hist_type low;
    drv_hist_type mid;
    drv_hist_type high;
    logic [7:0] drv;
    logic [7:0] err;
    logic bsy;
    logic drq;
    logic upper_byte_view;
    logic is48;
    logic vfy;
    logic lbam;
    logic [47:0] lba;
    logic [16:0] left;
    logic [15:0] word;
    logic full;
    logic [15:0] wcnt;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imsk;
    logic [15:0] rdata;
  } drv_regs_type;
endpackage

// file: sim/disk_read_verify_commands_bench.sv
// self-checking bench of the sector read/verify block
`timescale 1ns/1ps
module disk_read_verify_commands_bench;
  import drv_pkg::*;
  localparam int WPS = 4;
  logic clk;
  logic reset_n;
  logic ce;
  drv_bus_type bus;
  logic [15:0] rdata;
  drv_med_out_type med_out;
  drv_med_in_type med_in;
  logic irq;
  logic xfer;
  logic [47:0] bad;
  logic [1:0] lag;
  logic [31:0] seed = 32'hcfcc;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [7:0] ops [4] = '{8'h20, 8'h21, 8'h40, 8'h41};
  drv_cmd #(.WORDS_PER_SECTOR(WPS)) uut (.clk(clk), .reset_n(reset_n), .ce(ce), .bus(bus),
    .rdata(rdata), .med_out(med_out), .med_in(med_in), .irq(irq));
  drv_media_model #(.WPS(WPS)) media (.clk(clk), .med_out(med_out), .xfer(xfer), .bad(bad),
    .lag(lag), .med_in(med_in));
  // ==========
  // clock and helpers
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic summarize();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus <= {a, d, 2'b10};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    bus <= {a, 16'h0000, 2'b01};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
    v = rdata;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    logic [15:0] v;
    rd(a, v);
    cmp({8'h00, v[7:0]}, {8'h00, e});
  endtask
  task automatic poll(input int b, input logic w);
    logic [15:0] s;
    int n;
    n = 0;
    do begin
      rd(OFS_OPC, s);
      n++;
    end while (s[b] !== w && n < 4000);
    if (n >= 4000) begin
      error_cnt++;
      $display("CHECK FAILED %0t status poll timed out", $time);
      summarize();
    end
  endtask
  // ==========
  // one command: parameters, data, completion registers, interrupt
  task automatic run(input logic [7:0] op, input logic [47:0] b, input int n, input int bi, input logic lm);
    logic [47:0] a;
    logic [3:0][7:0] pv;
    logic [3:0][7:0] cv;
    logic [7:0] dv;
    logic [15:0] v;
    logic [2:0] mk;
    logic [2:0] ex;
    logic e48, ab, rdc, er;
    logic [47:0] f;
    int ns;
    e48 = (op == OPC_RD48);
    rdc = (op & OPC_MASK) != OPC_VF28;
    ab = e48 ? !lm : !((op & OPC_MASK) inside {OPC_RD28, OPC_VF28});
    er = !ab && bi < n;
    ns = ab ? 0 : (er ? bi : n);
    dv = e48 ? {1'b0, lm, 6'h00} : {1'b0, lm, 2'b00, b[27:24]};
    pv = {b[47:24], 8'(n >> 8)};
    cv = {b[23:0], 8'(n)};
    seed = xs(seed);
    mk = seed[2:0];
    f = b + 48'(bi);
    bad <= f;
    lag <= seed[4:3];
    xfer <= rdc;
    wr(OFS_IMSK, {13'h0000, mk});
    wr(4'hf, 16'hffff);
    for (int k = 0; k < 4; k++) begin
      if (e48) wr(OFS_CNT + 4'(k), {8'h00, pv[k]});
      wr(OFS_CNT + 4'(k), {8'h00, cv[k]});
    end
    wr(OFS_DRV, {8'h00, dv});
    wr(OFS_OPC, {8'h00, op});
    for (int s = 0; s < ns && rdc; s++) begin
      poll(ST_DRQ, 1'b1);
      a = b + 48'(s);
      for (int i = 0; i < WPS; i++) begin
        rd(OFS_WORD, v);
        cmp(v, {a[11:0], 4'(i)});
      end
      repeat (2) @(posedge clk);
    end
    poll(ST_BSY, 1'b0);
    rchk(OFS_OPC, (er || ab) ? 8'h51 : 8'h50);
    rchk(OFS_ERR, ab ? 8'h04 : (er ? (f[0] ? 8'h10 : 8'h40) : 8'h00));
    a = b + 48'(er ? bi : n - 1);
    if (!e48 && !ab) begin
      rchk(OFS_CNT, 8'(n - ns));
      rchk(OFS_LOW, a[7:0]);
      rchk(OFS_MID, a[15:8]);
      rchk(OFS_HIGH, a[23:16]);
      rchk(OFS_DRV, {dv[7:4], a[27:24]});
    end
    if (e48 && er) begin
      for (int h = 0; h < 2; h++) begin
        wr(OFS_CTL, {8'h00, h[0], 7'h00});
        for (int k = 1; k < 4; k++) rchk(OFS_CNT + 4'(k), a[8 * (k - 1) + 24 * h +: 8]);
      end
      wr(OFS_CTL, 16'h0000);
    end
    ex = {rdc && ns > 0, er || ab, 1'b1};
    cmp({15'h0000, irq}, {15'h0000, |(ex & mk)});
    rchk(OFS_IST, {5'h00, ex});
    cmp({15'h0000, irq}, 16'h0000);
  endtask
  // ==========
  // main sequence
  initial begin
    logic [47:0] b;
    bus = '0;
    reset_n = 1'b0;
    ce = 1'b1;
    xfer = 1'b0;
    bad = '1;
    lag = 2'd0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    cmp({rdata[14:0], irq}, 16'h0000);
    run(8'h41, 48'h0123456, 256, 300, 1'b1);
    run(8'h40, 48'h0abcdef, 10, 3, 1'b1);
    run(8'h21, {20'h0, 4'h2, 16'h0123, 8'h05}, 2, 1, 1'b0);
    run(OPC_RD48, 48'h0a0b0c0d0e0f, 258, 257, 1'b1);
    run(OPC_RD48, 48'h10, 1, 5, 1'b0);
    run(8'h30, 48'h10, 1, 5, 1'b1);
    run(OPC_RD48, 48'h123456789abd, 65536, 0, 1'b1);
    repeat (12) begin
      seed = xs(seed);
      b = {21'h0, seed[26:0]};
      seed = xs(seed);
      run(ops[seed[1:0]], b, 1 + int'(seed[3:2]), int'(seed[6:4]), 1'b1);
    end
    // stall, refused write and reset in the middle of a long verify
    bad <= '1;
    xfer <= 1'b0;
    wr(OFS_CNT, 16'h0000);
    wr(OFS_DRV, 16'h0040);
    wr(OFS_OPC, {8'h00, OPC_VF28});
    ce <= 1'b0;
    repeat (9) @(posedge clk);
    ce <= 1'b1;
    wr(OFS_CNT, 16'h0055);
    rchk(OFS_CNT, 8'h00);
    rchk(OFS_OPC, 8'hd0);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    rchk(OFS_OPC, 8'h50);
    rchk(OFS_IST, 8'h00);
    cmp({15'h0000, irq}, 16'h0000);
    run(8'h20, 48'h0000777, 2, 9, 1'b1);
    summarize();
  end
endmodule // disk_read_verify_commands_bench

// file: sim/drv_media_model.sv
// media side model answering sector requests and streaming words
`timescale 1ns/1ps
module drv_media_model #(
  parameter int WPS = 4
) (
  input wire logic clk,
  input wire drv_pkg::drv_med_out_type med_out,
  input wire logic xfer,
  input wire logic [47:0] bad,
  input wire logic [1:0] lag,
  output drv_pkg::drv_med_in_type med_in
);
  import drv_pkg::*;
  // ==========
  // sector answers, then words of a good read sector
  logic u;
  initial begin
    med_in = '0;
    forever begin
      @(posedge clk);
      if (med_out.req) begin
        repeat (lag) @(posedge clk);
        u = (med_out.lba == bad);
        med_in.ack <= 1'b1;
        med_in.unc <= u && !bad[0];
        med_in.idnf <= u && bad[0];
        @(posedge clk);
        med_in.ack <= 1'b0;
        med_in.unc <= ~u;
        med_in.idnf <= ~u;
        for (int i = 0; i < WPS && xfer && !u; i++) begin
          med_in.word_valid <= 1'b1;
          med_in.word <= {med_out.lba[11:0], 4'(i)};
          do @(posedge clk); while (!med_out.word_ready);
        end
        med_in.word_valid <= 1'b0;
        med_in.word <= ~med_in.word; // released lines do not hold
      end
    end
  end
endmodule // drv_media_model
